// ===== rtl/sup_pkg.sv
// Constants, register layout and modes of the regulator protection supervisor
// What this block does
// - Start-up: buck still low after 1 ms, disable
// - Running: buck low for 1 ms, disable
// - Fault sets short and summary flags, IRQ
// - Write-1 clears short flag; enabled buck retries
// - Overvoltage: regulators and outputs off, flag, IRQ
// - Overvoltage flag sticks while high; live bit
// - No enable during overvoltage or pending flag
// - Overtemperature: regulators off, flag, IRQ, standby
// - Thermal flag sticks while hot; live bit; block
// - Lockout: bucks off, pulldowns, shutdown, then standby
// - Reset flag after shutdown or software reset
// - Second output shares pin with sync clock
// - Type bit picks drive, level bit value
// - Per output, follow enable-pin sequencing or not
// - Inputs debounced by sampled counter
// - Enable pin window 3 us both edges
// - Lockout detector: 3 us rising, falling immediate
// - Overvoltage: 1 us rising, 20 us falling
// - Power good filtered 6 us both edges
// - Load-settings: regulators off, copy stored bits
// - Standby all bucks off; active when buck enabled
package sup_pkg;
    localparam int CLK_NS        = 10;
    localparam int EN_NS         = 3000;
    localparam int UVLO_RISE_NS  = 3000;
    localparam int OVP_RISE_NS   = 1000;
    localparam int OVP_FALL_NS   = 20000;
    localparam int TSD_NS        = 20000;
    localparam int PG_NS         = 6000;
    localparam int SC_NS         = 1000000;
    localparam int EN_CYC        = (EN_NS + CLK_NS - 1) / CLK_NS;
    localparam int UVLO_RISE_CYC = (UVLO_RISE_NS + CLK_NS - 1) / CLK_NS;
    localparam int UVLO_FALL_CYC = 0;
    localparam int OVP_RISE_CYC  = (OVP_RISE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OVP_FALL_CYC  = (OVP_FALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int TSD_CYC       = (TSD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PG_CYC        = (PG_NS + CLK_NS - 1) / CLK_NS;
    localparam int SC_CYC        = (SC_NS + CLK_NS - 1) / CLK_NS;
    localparam int FW            = 12;
    localparam int AW            = 8;
    localparam int RW            = 7;
    localparam logic [AW-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [AW-1:0] ADDR_GPO    = 8'h04;
    localparam logic [AW-1:0] ADDR_FLAGS  = 8'h08;
    localparam logic [AW-1:0] ADDR_MASK   = 8'h0c;
    localparam logic [AW-1:0] ADDR_STATUS = 8'h10;
    // Control register fields
    localparam int C_EN0  = 0;
    localparam int C_PIN0 = 2;
    localparam int C_PD0  = 4;
    localparam int C_SWR  = 6;
    // Output control register fields
    localparam int G_LVL0 = 0;
    localparam int G_OD0  = 2;
    localparam int G_SEQ0 = 4;
    localparam int G_SEL  = 6;
    // Flag and mask fields
    localparam int F_SC0  = 0;
    localparam int F_SUM0 = 2;
    localparam int F_OVP  = 4;
    localparam int F_TSD  = 5;
    localparam int F_RST  = 6;
    localparam logic [RW-1:0] CTRL_RST = 7'h00;
    localparam logic [RW-1:0] GPO_RST  = 7'h00;
    localparam logic [RW-1:0] MASK_RST = 7'h00;
    typedef enum logic [1:0] {
        M_SHUTDOWN = 2'b00,
        M_LOAD     = 2'b01,
        M_STANDBY  = 2'b10,
        M_ACTIVE   = 2'b11
    } mode_e;
endpackage

// ===== rtl/regulator_protection_supervisor.sv
// Protection supervisor: debounce, fault flags, buck and output control, APB
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module edge_filter #(
    parameter int RISE = 1,
    parameter int FALL = 1
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    import sup_pkg::*;
    localparam logic [FW-1:0] RISE_M1 = FW'(RISE > 0 ? RISE - 1 : 0);
    localparam logic [FW-1:0] FALL_M1 = FW'(FALL > 0 ? FALL - 1 : 0);
    logic          s1_q;
    logic          s2_q;
    logic [FW-1:0] cnt_q;
    logic [FW-1:0] lim;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign lim = s2_q ? RISE_M1 : FALL_M1;

    // Window is counted in whole clocks, so it is exact to one period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o   <= 1'b0;
            cnt_q <= '0;
        end else if (s2_q == q_o) begin
            cnt_q <= '0;
        end else if (cnt_q >= lim) begin
            q_o   <= s2_q;
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // edge_filter

module regulator_protection_supervisor
    import sup_pkg::*;
#(
    parameter int SC_WAIT = sup_pkg::SC_CYC
) (
    input  wire logic                  CLK_I,
    input  wire logic                  RST_I,
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [sup_pkg::AW-1:0] PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    input  wire logic                  ENABLE_PIN_I,
    input  wire logic                  MAIN_SUPPLY_OK_I,
    input  wire logic                  OVERVOLT_I,
    input  wire logic                  THERMAL_TRIP_I,
    input  wire logic                  BUCK_FEEDBACK_ZERO_LOW_I,
    input  wire logic                  BUCK_FEEDBACK_ONE_LOW_I,
    input  wire logic                  POWER_GOOD_PIN_I,
    input  wire logic [sup_pkg::RW-1:0] OTP_CTRL_I,
    input  wire logic [sup_pkg::RW-1:0] OTP_GPO_I,
    input  wire logic [sup_pkg::RW-1:0] OTP_MASK_I,
    output logic      [1:0]            BUCK_EN_O,
    output logic      [1:0]            PULLDOWN_O,
    output logic                       GENERAL_OUTPUT_ONE_O,
    output logic                       GENERAL_OUTPUT_ONE_OE_O,
    output logic                       GENERAL_OUTPUT_TWO_O,
    output logic                       GENERAL_OUTPUT_TWO_OE_O,
    output logic                       EXTERNAL_SYNC_CLOCK_SEL_O,
    output logic                       IRQ_OUT_N_O,
    output logic      [1:0]            MODE_O,
    output logic                       POWER_GOOD_O
);
    import sup_pkg::*;
    localparam logic [16:0] SC_M1 = 17'(SC_WAIT - 1);

    mode_e          mode_q;
    logic [RW-1:0]  ctrl_q;
    logic [RW-1:0]  gpo_q;
    logic [RW-1:0]  mask_q;
    logic [RW-1:0]  flags_q;
    logic [RW-1:0]  flag_set;
    logic [RW-1:0]  flag_clr;
    logic [1:0]     on_q;
    logic [1:0]     start_q;
    logic [16:0]    sc_cnt_q [2];
    logic [1:0]     fault;
    logic [1:0]     go;
    logic [1:0]     fb_s1_q;
    logic [1:0]     fb_s2_q;
    logic           en_f;
    logic           supply_f;
    logic           ovp_f;
    logic           tsd_f;
    logic           pg_f;
    logic           ovp_live;
    logic           block;
    logic           powered;
    logic           access;
    logic           wr;
    logic           swr;
    logic [2:0]     wr_idx;
    logic [1:0]     lvl;
    logic           out_off;

    function automatic logic [2:0] reg_index(input logic [AW-1:0] a);
        if (a == ADDR_CTRL) begin
            return 3'h0;
        end else if (a == ADDR_GPO) begin
            return 3'h1;
        end else if (a == ADDR_FLAGS) begin
            return 3'h2;
        end else if (a == ADDR_MASK) begin
            return 3'h3;
        end else if (a == ADDR_STATUS) begin
            return 3'h4;
        end else begin
            return 3'h7;
        end
    endfunction

    edge_filter #(.RISE(EN_CYC), .FALL(EN_CYC)) u_en (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (ENABLE_PIN_I),
        .q_o   (en_f)
    );
    edge_filter #(.RISE(UVLO_RISE_CYC), .FALL(UVLO_FALL_CYC)) u_uvlo (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (MAIN_SUPPLY_OK_I),
        .q_o   (supply_f)
    );
    edge_filter #(.RISE(OVP_RISE_CYC), .FALL(OVP_FALL_CYC)) u_ovp (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (OVERVOLT_I),
        .q_o   (ovp_f)
    );
    edge_filter #(.RISE(TSD_CYC), .FALL(TSD_CYC)) u_tsd (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (THERMAL_TRIP_I),
        .q_o   (tsd_f)
    );
    edge_filter #(.RISE(PG_CYC), .FALL(PG_CYC)) u_pg (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (POWER_GOOD_PIN_I),
        .q_o   (pg_f)
    );

    // Feedback comparators are asynchronous; the 1 ms timer does the filtering
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fb_s1_q <= 2'b00;
            fb_s2_q <= 2'b00;
        end else begin
            fb_s1_q <= {BUCK_FEEDBACK_ONE_LOW_I, BUCK_FEEDBACK_ZERO_LOW_I};
            fb_s2_q <= fb_s1_q;
        end
    end

    assign powered  = (mode_q == M_STANDBY) || (mode_q == M_ACTIVE);
    assign ovp_live = ovp_f & powered;
    assign block    = ovp_live | flags_q[F_OVP] | tsd_f | flags_q[F_TSD];
    assign access   = PSEL_I & PENABLE_I & PREADY_O;
    assign wr_idx   = reg_index(PADDR_I);
    assign wr       = access & PWRITE_I & powered;
    assign swr      = wr & (wr_idx == 3'h0) & PWDATA_I[C_SWR];

    // Buck enable, start-up check and overload timer per regulator.
    // Held off while its short flag is pending; clearing it retries.
    // A software reset drops the bucks in the same edge as the mode change
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            go[i] = ctrl_q[C_EN0+i] & (~ctrl_q[C_PIN0+i] | en_f)
                    & ~block & powered & ~flags_q[F_SC0+i]
                    & ~swr;
            fault[i] = on_q[i] & fb_s2_q[i] & (sc_cnt_q[i] == SC_M1);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            on_q        <= 2'b00;
            start_q     <= 2'b00;
            sc_cnt_q[0] <= '0;
            sc_cnt_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                on_q[i] <= go[i] & ~fault[i];
                if (!on_q[i]) begin
                    start_q[i]  <= go[i];
                    sc_cnt_q[i] <= '0;
                end else if (start_q[i] | fb_s2_q[i]) begin
                    if (sc_cnt_q[i] == SC_M1) begin
                        start_q[i]  <= 1'b0;
                        sc_cnt_q[i] <= '0;
                    end else begin
                        sc_cnt_q[i] <= sc_cnt_q[i] + 17'h1;
                    end
                end else begin
                    sc_cnt_q[i] <= '0;
                end
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_q <= M_SHUTDOWN;
        end else if (!supply_f) begin
            mode_q <= M_SHUTDOWN;
        end else if (swr) begin
            mode_q <= M_LOAD;
        end else begin
            case (mode_q)
                M_SHUTDOWN: mode_q <= M_LOAD;
                M_LOAD:     mode_q <= M_STANDBY;
                M_STANDBY:  if (|on_q) mode_q <= M_ACTIVE;
                M_ACTIVE:   if (~|on_q) mode_q <= M_STANDBY;
                default:    mode_q <= M_SHUTDOWN;
            endcase
        end
    end

    // Settings survive shutdown so the pulldowns keep discharging there
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl_q <= CTRL_RST;
            gpo_q  <= GPO_RST;
            mask_q <= MASK_RST;
        end else if (mode_q == M_LOAD) begin
            ctrl_q <= OTP_CTRL_I;
            gpo_q  <= OTP_GPO_I;
            mask_q <= OTP_MASK_I;
        end else if (wr && !swr) begin
            if (wr_idx == 3'h0) begin
                ctrl_q <= PWDATA_I[RW-1:0] & ~(7'h1 << C_SWR);
            end else if (wr_idx == 3'h1) begin
                gpo_q <= PWDATA_I[RW-1:0];
            end else if (wr_idx == 3'h3) begin
                mask_q <= PWDATA_I[RW-1:0];
            end
        end
    end

    always_comb begin
        flag_set         = '0;
        flag_set[F_SC0]  = fault[0];
        flag_set[F_SC0+1] = fault[1];
        flag_set[F_SUM0] = fault[0];
        flag_set[F_SUM0+1] = fault[1];
        flag_set[F_OVP]  = ovp_live;
        flag_set[F_TSD]  = tsd_f & powered;
        flag_clr = (wr && wr_idx == 3'h2) ? PWDATA_I[RW-1:0] : '0;
    end

    // A set in the clearing cycle wins; live faults re-set every cycle
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            flags_q <= '0;
        end else if (mode_q == M_LOAD) begin
            flags_q        <= '0;
            flags_q[F_RST] <= ~OTP_MASK_I[F_RST];
        end else begin
            flags_q <= flag_set | (flags_q & ~flag_clr);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            IRQ_OUT_N_O <= 1'b1;
        end else begin
            IRQ_OUT_N_O <= ~|(flags_q & ~mask_q);
        end
    end

    assign out_off = ovp_live | flags_q[F_OVP] | ~powered;
    assign lvl[0]  = gpo_q[G_LVL0] & (~gpo_q[G_SEQ0] | en_f) & ~out_off;
    assign lvl[1]  = gpo_q[G_LVL0+1] & (~gpo_q[G_SEQ0+1] | en_f) & ~out_off;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            BUCK_EN_O                 <= 2'b00;
            PULLDOWN_O                <= 2'b00;
            GENERAL_OUTPUT_ONE_O      <= 1'b0;
            GENERAL_OUTPUT_ONE_OE_O   <= 1'b0;
            GENERAL_OUTPUT_TWO_O      <= 1'b0;
            GENERAL_OUTPUT_TWO_OE_O   <= 1'b0;
            EXTERNAL_SYNC_CLOCK_SEL_O <= 1'b0;
            MODE_O                    <= 2'b00;
            POWER_GOOD_O              <= 1'b0;
        end else begin
            BUCK_EN_O  <= on_q;
            PULLDOWN_O <= ~on_q & ctrl_q[C_PD0+1:C_PD0];
            // Open drain only ever sinks: low means enable the driver
            GENERAL_OUTPUT_ONE_O    <= ~gpo_q[G_OD0] & lvl[0];
            GENERAL_OUTPUT_ONE_OE_O <= ~gpo_q[G_OD0] | ~lvl[0];
            if (gpo_q[G_SEL]) begin
                GENERAL_OUTPUT_TWO_O    <= 1'b0;
                GENERAL_OUTPUT_TWO_OE_O <= 1'b0;
            end else begin
                GENERAL_OUTPUT_TWO_O    <= ~gpo_q[G_OD0+1] & lvl[1];
                GENERAL_OUTPUT_TWO_OE_O <= ~gpo_q[G_OD0+1] | ~lvl[1];
            end
            EXTERNAL_SYNC_CLOCK_SEL_O <= gpo_q[G_SEL];
            MODE_O                    <= mode_q;
            POWER_GOOD_O              <= pg_f;
        end
    end

    // No wait state: answer is prepared in the setup cycle
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && !PENABLE_I) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= (wr_idx == 3'h7);
            if (PWRITE_I || wr_idx == 3'h7) begin
                PRDATA_O <= 32'h0;
            end else if (wr_idx == 3'h0) begin
                PRDATA_O <= {25'h0, ctrl_q};
            end else if (wr_idx == 3'h1) begin
                PRDATA_O <= {25'h0, gpo_q};
            end else if (wr_idx == 3'h2) begin
                PRDATA_O <= {25'h0, flags_q};
            end else if (wr_idx == 3'h3) begin
                PRDATA_O <= {25'h0, mask_q};
            end else begin
                PRDATA_O <= {25'h0, pg_f, mode_q, tsd_f, ovp_live,
                             on_q};
            end
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0;
        end
    end
endmodule // regulator_protection_supervisor

`default_nettype wire

// ===== tb/supervisor_checker_sva.sv
// Port-level assertions for the protection supervisor
`timescale 1ns/10ps
`default_nettype none
module supervisor_checker #(
    parameter int SC_WAIT = 50
) (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic        MAIN_SUPPLY_OK_I,
    input wire logic        OVERVOLT_I,
    input wire logic        THERMAL_TRIP_I,
    input wire logic        BUCK_FEEDBACK_ZERO_LOW_I,
    input wire logic        POWER_GOOD_PIN_I,
    input wire logic [1:0]  BUCK_EN_O,
    input wire logic        GENERAL_OUTPUT_ONE_O,
    input wire logic        GENERAL_OUTPUT_ONE_OE_O,
    input wire logic        GENERAL_OUTPUT_TWO_O,
    input wire logic        GENERAL_OUTPUT_TWO_OE_O,
    input wire logic        EXTERNAL_SYNC_CLOCK_SEL_O,
    input wire logic [1:0]  MODE_O,
    input wire logic        POWER_GOOD_O
);
    import sup_pkg::*;
    // Saturating run lengths of the raw inputs
    logic [11:0] ovp_q, hot_q, pg_q;
    logic [15:0] low_q;
    always_ff @(posedge CLK_I) begin
        if (RST_I || !OVERVOLT_I) ovp_q <= '0;
        else if (ovp_q != 12'hfff) ovp_q <= ovp_q + 12'h001;
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I || !THERMAL_TRIP_I) hot_q <= '0;
        else if (hot_q != 12'hfff) hot_q <= hot_q + 12'h001;
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I || $changed(POWER_GOOD_PIN_I)) pg_q <= '0;
        else if (pg_q != 12'hfff) pg_q <= pg_q + 12'h001;
    end
    always_ff @(posedge CLK_I) begin
        if (RST_I || !(BUCK_EN_O[0] && BUCK_FEEDBACK_ZERO_LOW_I)) low_q <= '0;
        else if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_error_no_data: assert property (
        PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0) else $error("bad error");
    a_ovp_outputs_off: assert property (
        ovp_q >= 12'h078 |-> BUCK_EN_O == 2'b00 && !GENERAL_OUTPUT_ONE_O
        && !GENERAL_OUTPUT_TWO_O) else $error("outputs on in overvoltage");
    a_hot_bucks_off: assert property (
        hot_q >= 12'h7e4 |-> BUCK_EN_O == 2'b00 && MODE_O != M_ACTIVE)
        else $error("bucks on while hot");
    a_lockout_off: assert property (
        !MAIN_SUPPLY_OK_I [*5] |=> MODE_O == M_SHUTDOWN ##1 BUCK_EN_O == 2'b00)
        else $error("no shutdown on lockout");
    a_load_bucks_off: assert property (
        MODE_O == M_LOAD |-> BUCK_EN_O == 2'b00) else $error("bucks on in load");
    a_short_bound: assert property (
        low_q <= SC_WAIT + 8) else $error("low output not cut off");
    a_pin_shared: assert property (
        EXTERNAL_SYNC_CLOCK_SEL_O |-> !GENERAL_OUTPUT_TWO_OE_O
        && !GENERAL_OUTPUT_TWO_O) else $error("clock pin driven");
    a_drive_type: assert property (
        !GENERAL_OUTPUT_ONE_OE_O |-> !GENERAL_OUTPUT_ONE_O)
        else $error("released pin carries high");
    a_pg_settled: assert property (
        $changed(POWER_GOOD_O) |-> pg_q >= 12'h253) else $error("pg too soon");
endmodule // supervisor_checker
bind regulator_protection_supervisor supervisor_checker #(.SC_WAIT(SC_WAIT))
    supervisor_checker_inst (.CLK_I, .RST_I, .PREADY_O, .PSLVERR_O,
    .PRDATA_O, .MAIN_SUPPLY_OK_I, .OVERVOLT_I, .THERMAL_TRIP_I,
    .BUCK_FEEDBACK_ZERO_LOW_I, .POWER_GOOD_PIN_I, .BUCK_EN_O,
    .GENERAL_OUTPUT_ONE_O, .GENERAL_OUTPUT_ONE_OE_O, .GENERAL_OUTPUT_TWO_O,
    .GENERAL_OUTPUT_TWO_OE_O, .EXTERNAL_SYNC_CLOCK_SEL_O, .MODE_O,
    .POWER_GOOD_O);
`default_nettype wire

// ===== tb/host_model.sv
// Host processor model: APB master noting each expected answer
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic                 clk_i,
    input  wire logic                 pready_i,
    output var logic                  psel_o,
    output var logic                  penable_o,
    output var logic                  pwrite_o,
    output var logic [sup_pkg::AW-1:0] paddr_o,
    output var logic [31:0]           pwdata_o
);
    import sup_pkg::*;
    logic [33:0] notes[$];
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = '0;
        pwdata_o = '0;
    end
    // Request is held until ready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [AW-1:0] a,
                        input logic [31:0] d, input logic [32:0] e);
        notes.push_back({~w, e});
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
    task automatic clear_flags(input logic [31:0] m);
        xfer(1'b1, ADDR_FLAGS, m, 33'h0);
    endtask
endmodule // host_model
`default_nettype wire

// ===== tb/regulator_protection_supervisor_test.sv
// Self-checking bench for the regulator protection supervisor
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
    n_errors++; $display("wrong value at %0t: got %h expected %h", \
    $time, got, exp); end end
module regulator_protection_supervisor_test;
    import sup_pkg::*;
    localparam int SCW = 50;
    logic CLK_I = 1'b0, RST_I = 1'b1, ENABLE_PIN_I = 1'b0;
    logic MAIN_SUPPLY_OK_I = 1'b1, OVERVOLT_I = 1'b0, THERMAL_TRIP_I = 1'b0;
    logic POWER_GOOD_PIN_I = 1'b0, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O;
    logic [AW-1:0] PADDR_I;
    logic [31:0] PWDATA_I, PRDATA_O, v;
    logic [RW-1:0] OTP_CTRL_I = '0, OTP_GPO_I = '0, OTP_MASK_I = '0;
    logic [1:0] BUCK_EN_O, PULLDOWN_O, MODE_O, up_q = 2'b00, short_q = 2'b00;
    logic PSLVERR_O, GENERAL_OUTPUT_ONE_O, GENERAL_OUTPUT_ONE_OE_O;
    logic GENERAL_OUTPUT_TWO_O, GENERAL_OUTPUT_TWO_OE_O, IRQ_OUT_N_O;
    logic EXTERNAL_SYNC_CLOCK_SEL_O, POWER_GOOD_O;
    logic [33:0] note;
    int n_errors = 0, checks_done = 0, cycles = 0, seed = 29569, i;
    always #5 CLK_I = ~CLK_I;
    // Output voltage comes up one cycle after enable unless shorted
    always @(posedge CLK_I) up_q <= BUCK_EN_O;
    wire logic [1:0] fb_lo = ~up_q | short_q;
    regulator_protection_supervisor #(.SC_WAIT(SCW))
        regulator_protection_supervisor_inst (.CLK_I, .RST_I, .PSEL_I,
        .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O,
        .PSLVERR_O, .ENABLE_PIN_I, .MAIN_SUPPLY_OK_I, .OVERVOLT_I,
        .THERMAL_TRIP_I, .BUCK_FEEDBACK_ZERO_LOW_I(fb_lo[0]),
        .BUCK_FEEDBACK_ONE_LOW_I(fb_lo[1]), .POWER_GOOD_PIN_I, .OTP_CTRL_I,
        .OTP_GPO_I, .OTP_MASK_I, .BUCK_EN_O, .PULLDOWN_O,
        .GENERAL_OUTPUT_ONE_O, .GENERAL_OUTPUT_ONE_OE_O, .GENERAL_OUTPUT_TWO_O,
        .GENERAL_OUTPUT_TWO_OE_O, .EXTERNAL_SYNC_CLOCK_SEL_O, .IRQ_OUT_N_O,
        .MODE_O, .POWER_GOOD_O);
    host_model host_model_inst (.clk_i(CLK_I), .pready_i(PREADY_O),
        .psel_o(PSEL_I), .penable_o(PENABLE_I), .pwrite_o(PWRITE_I),
        .paddr_o(PADDR_I), .pwdata_o(PWDATA_I));
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [32:0] e);
        host_model_inst.xfer(1'b0, a, 32'h0, e);
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        host_model_inst.xfer(1'b1, a, d, 33'h0);
    endtask
    task automatic stby;
        cyc(3);
        wait (MODE_O === M_STANDBY);
        cyc(1);
    endtask
    // Answers are checked against the oldest note when ready is seen
    always @(posedge CLK_I) begin
        if (PSEL_I && PENABLE_I && PREADY_O === 1'b1
            && host_model_inst.notes.size() > 0) begin
            note = host_model_inst.notes.pop_front();
            if (note[33]) `CHK(PRDATA_O, note[31:0]);
            `CHK(PSLVERR_O, note[32]);
        end
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        cyc(3);
        RST_I <= 1'b0;
        stby();
        rd(ADDR_CTRL, 33'h0);
        rd(ADDR_FLAGS, 33'h40);
        rd(8'h14, 33'h1_0000_0000);
        `CHK(IRQ_OUT_N_O, 1'b0);
        host_model_inst.clear_flags(32'h40);
        cyc(3);
        `CHK(IRQ_OUT_N_O, 1'b1);
        rd(ADDR_STATUS, 33'h20);
        wr(ADDR_CTRL, 32'h33);
        cyc(10);
        `CHK(MODE_O, M_ACTIVE);
        rd(ADDR_STATUS, 33'h33);
        $display("reset and start test done");
        short_q <= 2'b01;
        cyc(SCW + 10);
        `CHK(BUCK_EN_O, 2'b10);
        `CHK(IRQ_OUT_N_O, 1'b0);
        rd(ADDR_FLAGS, 33'h05);
        rd(ADDR_STATUS, 33'h32);
        host_model_inst.clear_flags(32'h01);
        cyc(4);
        `CHK(BUCK_EN_O, 2'b11);
        cyc(SCW + 10);
        `CHK(BUCK_EN_O, 2'b10);
        short_q <= 2'b00;
        host_model_inst.clear_flags(32'h05);
        cyc(10);
        `CHK(BUCK_EN_O, 2'b11);
        rd(ADDR_FLAGS, 33'h0);
        $display("short test done");
        OVERVOLT_I <= 1'b1;
        cyc(130);
        `CHK({BUCK_EN_O, PULLDOWN_O, IRQ_OUT_N_O}, 5'b00110);
        rd(ADDR_STATUS, 33'h24);
        host_model_inst.clear_flags(32'h10);
        rd(ADDR_FLAGS, 33'h10);
        OVERVOLT_I <= 1'b0;
        cyc(2020);
        `CHK(BUCK_EN_O, 2'b00);
        host_model_inst.clear_flags(32'h10);
        cyc(5);
        `CHK(BUCK_EN_O, 2'b11);
        $display("overvoltage test done");
        THERMAL_TRIP_I <= 1'b1;
        cyc(2030);
        `CHK({BUCK_EN_O, MODE_O}, {2'b00, M_STANDBY});
        host_model_inst.clear_flags(32'h20);
        rd(ADDR_FLAGS, 33'h20);
        rd(ADDR_STATUS, 33'h28);
        THERMAL_TRIP_I <= 1'b0;
        cyc(2030);
        `CHK(BUCK_EN_O, 2'b00);
        host_model_inst.clear_flags(32'h20);
        cyc(5);
        `CHK(BUCK_EN_O, 2'b11);
        $display("thermal test done");
        for (i = 0; i < 6; i++) begin
            v = ($random(seed) & 32'h0f) | {25'h0, i[0], 6'h0};
            wr(ADDR_GPO, v);
            cyc(3);
            `CHK({GENERAL_OUTPUT_ONE_O, GENERAL_OUTPUT_ONE_OE_O}, v[2] ? {1'b0, ~v[0]} : {v[0], 1'b1});
            `CHK({GENERAL_OUTPUT_TWO_O, GENERAL_OUTPUT_TWO_OE_O, EXTERNAL_SYNC_CLOCK_SEL_O}, v[6] ? 3'b001 : {v[3] ? {1'b0, ~v[1]} : {v[1], 1'b1}, 1'b0});
            rd(ADDR_GPO, {1'b0, v});
        end
        $display("output test done");
        POWER_GOOD_PIN_I <= 1'b1;
        cyc(620);
        `CHK(POWER_GOOD_O, 1'b1);
        POWER_GOOD_PIN_I <= 1'b0;
        cyc(300);
        `CHK(POWER_GOOD_O, 1'b1);
        cyc(320);
        `CHK(POWER_GOOD_O, 1'b0);
        $display("power good test done");
        wr(ADDR_CTRL, 32'h3f);
        cyc(5);
        `CHK(BUCK_EN_O, 2'b00);
        ENABLE_PIN_I <= 1'b1;
        cyc(295);
        `CHK(BUCK_EN_O, 2'b00);
        cyc(15);
        `CHK(BUCK_EN_O, 2'b11);
        $display("enable pin test done");
        OTP_GPO_I <= 7'h01;
        wr(ADDR_CTRL, 32'h40);
        stby();
        rd(ADDR_CTRL, 33'h0);
        rd(ADDR_FLAGS, 33'h40);
        rd(ADDR_GPO, 33'h01);
        wr(ADDR_CTRL, 32'h33);
        cyc(5);
        MAIN_SUPPLY_OK_I <= 1'b0;
        cyc(7);
        `CHK({MODE_O, BUCK_EN_O, PULLDOWN_O}, {M_SHUTDOWN, 4'b0011});
        MAIN_SUPPLY_OK_I <= 1'b1;
        stby();
        rd(ADDR_FLAGS, 33'h40);
        $display("reset and lockout test done");
        give_verdict();
    end
endmodule // regulator_protection_supervisor_test
`default_nettype wire
